// *** verilog/scis_device.sv ***
`timescale 1ns/10ps
module scis_device #(
  parameter int CFG_BITS = scis_pkg::CFG_BITS_DEF,
  parameter int INIT_CYCLES = scis_pkg::INIT_MIN_CYCLES,
  parameter int WDOG_CYCLES = scis_pkg::WDOG_CYC_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  scis_link_if.device lnk,
  input wire logic user_startup_clock,
  input wire scis_pkg::scis_init_src_t init_src,
  input wire logic quad_mode,
  input wire logic dual_purpose_en,
  input wire logic wdog_en,
  output logic user_mode,
  output logic user_io_in,
  output logic wdog_fired
);
  import scis_pkg::*;

  typedef enum logic [2:0] {ST_RESET, ST_RELEASE, ST_CONFIG, ST_FALLS, ST_USR_DLY, ST_INIT, ST_USER} scis_dev_st_t;

  localparam logic [2:0] STB_SEEN = 3'(STROBE_SEEN_CYC);

  // ------------------------------------------------------------
  // link clock domain
  // ------------------------------------------------------------
  logic lrst_s1_r;
  logic lrst_s2_r;
  logic rise_tog_r;
  logic fall_tog_r;
  logic [4:0] cap_r;

  // link clock only runs in frames; the host primes it once after power-up
  always_ff @(posedge lnk.cfg_serial_clock) begin
    lrst_s1_r <= rst_b;
    lrst_s2_r <= lrst_s1_r;
  end

  // both widths are captured; the system side picks by mode, so no mode crossing
  always_ff @(posedge lnk.cfg_serial_clock) begin
    if (!lrst_s2_r) begin
      rise_tog_r <= 1'b0;
      cap_r <= 5'h00;
    end else begin
      rise_tog_r <= ~rise_tog_r;
      cap_r <= {lnk.flash_data_lines, lnk.serial_config_data_in};
    end
  end

  always_ff @(negedge lnk.cfg_serial_clock) begin
    if (!lrst_s2_r) begin
      fall_tog_r <= 1'b0;
    end else begin
      fall_tog_r <= ~fall_tog_r;
    end
  end

  // ------------------------------------------------------------
  // synchronisers into the system domain
  // ------------------------------------------------------------
  logic [2:0] rise_s_r;
  logic [2:0] fall_s_r;
  logic [2:0] usr_s_r;
  logic [1:0] req_s_r;
  logic [1:0] stat_s_r;
  logic [1:0] dat_s_r;
  logic [1:0] stb_s1_r;
  logic [1:0] stb_s2_r;
  logic [2:0] stb_cnt_r [2];
  logic [1:0] stb_hit_r;

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rise_s_r <= 3'h0;
      fall_s_r <= 3'h0;
      usr_s_r <= 3'h0;
      req_s_r <= 2'h3;
      stat_s_r <= 2'h0;
      dat_s_r <= 2'h0;
    end else begin
      rise_s_r <= {rise_s_r[1:0], rise_tog_r};
      fall_s_r <= {fall_s_r[1:0], fall_tog_r};
      usr_s_r <= {usr_s_r[1:0], user_startup_clock};
      req_s_r <= {req_s_r[0], lnk.cfg_request_n};
      stat_s_r <= {stat_s_r[0], lnk.status_n};
      dat_s_r <= {dat_s_r[0], lnk.serial_config_data_in};
    end
  end

  logic rise_ev;
  logic fall_ev;
  logic usr_ev;
  assign rise_ev = rise_s_r[2] ^ rise_s_r[1];
  assign fall_ev = fall_s_r[2] ^ fall_s_r[1];
  assign usr_ev = usr_s_r[1] & ~usr_s_r[2];

  // ------------------------------------------------------------
  // strobe width filters: [0] reconfiguration, [1] watchdog reset
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stb_s1_r <= 2'h0;
      stb_s2_r <= 2'h0;
      stb_hit_r <= 2'h0;
      for (int i = 0; i < 2; i++) begin
        stb_cnt_r[i] <= 3'h0;
      end
    end else begin
      stb_s1_r <= {lnk.watchdog_reset_strobe, lnk.remote_reconfig_strobe};
      stb_s2_r <= stb_s1_r;
      for (int i = 0; i < 2; i++) begin
        if (!stb_s2_r[i]) begin
          stb_cnt_r[i] <= 3'h0;
        end else if (stb_cnt_r[i] != STB_SEEN) begin
          stb_cnt_r[i] <= stb_cnt_r[i] + 3'h1;
        end
        // one pulse per strobe, only once it has been high long enough
        stb_hit_r[i] <= stb_s2_r[i] && (stb_cnt_r[i] == STB_SEEN - 3'h1);
      end
    end
  end

  // ------------------------------------------------------------
  // configuration and initialisation sequencer
  // ------------------------------------------------------------
  scis_dev_st_t st_r;
  logic [31:0] tmr_r;
  logic [31:0] bit_cnt_r;
  logic [31:0] bits_nxt;
  logic [31:0] wdog_cnt_r;
  logic status_low_r;
  logic done_r;
  logic init_en_r;
  logic user_r;
  logic user_io_r;
  logic wdog_fired_r;
  logic wdog_hit;
  logic restart;
  logic init_tick;
  logic [31:0] init_lim;
  scis_init_src_t eff_src;

  // the link clock is no init source when a flash supplies the clock
  assign eff_src = (init_src == SCIS_SRC_CFG_SERIAL_CLOCK && quad_mode) ? SCIS_SRC_OSC : init_src;
  assign init_tick = (eff_src == SCIS_SRC_OSC) || (eff_src == SCIS_SRC_USR && usr_ev) ||
                     (eff_src == SCIS_SRC_CFG_SERIAL_CLOCK && fall_ev);
  assign init_lim = (eff_src == SCIS_SRC_OSC) ? 32'(OSC_INIT_CYC) : 32'(INIT_CYCLES);
  assign bits_nxt = bit_cnt_r + (quad_mode ? 32'd4 : 32'd1);
  assign wdog_hit = wdog_en && (wdog_cnt_r == 32'(WDOG_CYCLES - 1));
  assign restart = !req_s_r[1] || (st_r == ST_USER && (stb_hit_r[0] || wdog_hit));

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r <= ST_RESET;
      tmr_r <= 32'h0000_0000;
      bit_cnt_r <= 32'h0000_0000;
      status_low_r <= 1'b1;
      done_r <= 1'b0;
      init_en_r <= 1'b0;
      user_r <= 1'b0;
    end else if (restart && st_r != ST_RESET) begin
      st_r <= ST_RESET;
      tmr_r <= 32'h0000_0000;
      status_low_r <= 1'b1;
      done_r <= 1'b0;
      init_en_r <= 1'b0;
      user_r <= 1'b0;
    end else begin
      unique case (st_r)
        ST_RESET: begin
          if (tmr_r != 32'(STATUS_LOW_CYC)) begin
            tmr_r <= tmr_r + 32'd1;
          end
          // held while the request stays low, so it may stretch past the maximum
          if (tmr_r >= 32'(STATUS_LOW_CYC - 1) && req_s_r[1]) begin
            status_low_r <= 1'b0;
            st_r <= ST_RELEASE;
          end
        end
        ST_RELEASE: begin
          // the host may extend the reset by holding the status line low
          if (stat_s_r[1]) begin
            bit_cnt_r <= 32'h0000_0000;
            st_r <= ST_CONFIG;
          end
        end
        ST_CONFIG: begin
          if (rise_ev) begin
            bit_cnt_r <= bits_nxt;
            if (bit_cnt_r == 32'h0000_0000) begin
              init_en_r <= quad_mode ? cap_r[1] : cap_r[0];
            end
            if (bits_nxt >= 32'(CFG_BITS)) begin
              done_r <= 1'b1;
              tmr_r <= 32'h0000_0000;
              st_r <= ST_FALLS;
            end
          end
        end
        ST_FALLS: begin
          if (fall_ev) begin
            tmr_r <= tmr_r + 32'd1;
            if (tmr_r == 32'(POST_DONE_FALLS - 1)) begin
              tmr_r <= 32'h0000_0000;
              st_r <= (eff_src == SCIS_SRC_USR) ? ST_USR_DLY : ST_INIT;
            end
          end
        end
        ST_USR_DLY: begin
          tmr_r <= tmr_r + 32'd1;
          if (tmr_r == 32'(USR_EN_CYC - 1)) begin
            tmr_r <= 32'h0000_0000;
            st_r <= ST_INIT;
          end
        end
        ST_INIT: begin
          if (init_tick) begin
            tmr_r <= tmr_r + 32'd1;
            if (tmr_r == init_lim - 32'd1) begin
              user_r <= 1'b1;
              st_r <= ST_USER;
            end
          end
        end
        ST_USER: begin
          user_r <= 1'b1;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // watchdog and user pin
  // ------------------------------------------------------------
  // counts the internal oscillator, so real timeout varies with its spread
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wdog_cnt_r <= 32'h0000_0000;
    end else if (st_r != ST_USER || !wdog_en || stb_hit_r[1] || wdog_hit) begin
      wdog_cnt_r <= 32'h0000_0000;
    end else begin
      wdog_cnt_r <= wdog_cnt_r + 32'd1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      wdog_fired_r <= 1'b0;
    end else if (st_r == ST_USER && wdog_hit) begin
      wdog_fired_r <= 1'b1;
    end else if (st_r == ST_CONFIG) begin
      wdog_fired_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      user_io_r <= 1'b0;
    end else begin
      user_io_r <= (st_r == ST_USER && dual_purpose_en) ? dat_s_r[1] : 1'b0;
    end
  end

  assign lnk.dev_status_pull_low = status_low_r;
  assign lnk.conf_done = done_r;
  assign lnk.init_done_oe = init_en_r;
  assign lnk.init_done_o = user_r;
  assign user_mode = user_r;
  assign user_io_in = user_io_r;
  assign wdog_fired = wdog_fired_r;

endmodule

// *** verilog/scis_pkg.sv ***
package scis_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int SYS_CLK_NS = 100;
  localparam int CFG_LOW_MIN_NS = 2000;
  localparam int CFG_LOW_CYC = (CFG_LOW_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int STATUS_LOW_MIN_US = 268;
  localparam int STATUS_LOW_CYC = (STATUS_LOW_MIN_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int ST2CK_MIN_NS = 2000;
  localparam int ST2CK_CYC = (ST2CK_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int CD2UM_MIN_US = 175;
  localparam int OSC_INIT_CYC = (CD2UM_MIN_US * 1000 + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int INIT_MIN_CYCLES = 8576;
  localparam int CFG_SERIAL_CLOCK_MAX_MHZ = 125;
  localparam int USR_EN_PERIODS = 4;
  localparam int USR_EN_NS = USR_EN_PERIODS * 1000 / CFG_SERIAL_CLOCK_MAX_MHZ;
  localparam int USR_EN_CYC = (USR_EN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  localparam int STROBE_MIN_NS = 250;
  localparam int STROBE_CYC = (STROBE_MIN_NS + SYS_CLK_NS - 1) / SYS_CLK_NS;
  // a strobe seen through a synchroniser shows at least this many samples
  localparam int STROBE_SEEN_CYC = STROBE_MIN_NS / SYS_CLK_NS;

  // ------------------------------------------------------------
  // sequence counts and defaults
  // ------------------------------------------------------------
  localparam int POST_DONE_FALLS = 2;
  localparam int PRIME_EDGES = 4;
  localparam int CFG_BITS_DEF = 64;
  localparam int WDOG_CYC_DEF = 100000;
  localparam int CFG_SERIAL_CLOCK_DIV_DEF = 4;

  typedef enum logic [1:0] {SCIS_SRC_OSC, SCIS_SRC_USR, SCIS_SRC_CFG_SERIAL_CLOCK} scis_init_src_t;

endpackage

// *** verilog/scis_link_if.sv ***
`timescale 1ns/10ps
interface scis_link_if;
  logic cfg_request_n;
  logic cfg_serial_clock;
  logic serial_config_data_in;
  logic [3:0] flash_data_lines;
  logic dev_status_pull_low;
  logic host_status_pull_low;
  logic status_n;
  logic conf_done;
  logic init_done_o;
  logic init_done_oe;
  logic init_done;
  logic remote_reconfig_strobe;
  logic watchdog_reset_strobe;

  // open-drain status with pull-up: either party may hold it low
  assign status_n = ~(dev_status_pull_low | host_status_pull_low);
  assign init_done = init_done_oe ? init_done_o : 1'b1;

  modport device (
    input cfg_request_n, cfg_serial_clock, serial_config_data_in, flash_data_lines, status_n,
    input remote_reconfig_strobe, watchdog_reset_strobe,
    output dev_status_pull_low, conf_done, init_done_o, init_done_oe
  );
  modport host (
    output cfg_request_n, cfg_serial_clock, serial_config_data_in, flash_data_lines,
    output host_status_pull_low, remote_reconfig_strobe, watchdog_reset_strobe,
    input status_n, conf_done, init_done
  );
endinterface

// *** verilog/scis_host.sv ***
`timescale 1ns/10ps
module scis_host #(
  parameter int CFG_BITS = scis_pkg::CFG_BITS_DEF,
  parameter int INIT_CYCLES = scis_pkg::INIT_MIN_CYCLES,
  parameter int CFG_SERIAL_CLOCK_DIV = scis_pkg::CFG_SERIAL_CLOCK_DIV_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  scis_link_if.host lnk,
  input wire logic cfg_start,
  input wire logic quad_mode,
  input wire scis_pkg::scis_init_src_t init_src,
  input wire logic hold_status_low,
  input wire logic [3:0] stream_data,
  input wire logic reconfig_req,
  input wire logic wdog_kick_req,
  output logic stream_take,
  output logic busy,
  output logic cfg_ok
);
  import scis_pkg::*;

  typedef enum logic [3:0] {H_BOOT, H_PRIME, H_IDLE, H_CFG_LOW, H_WAIT_ST, H_GAP, H_SEND, H_WAIT_DONE,
                            H_TRAIL} scis_host_st_t;

  // ------------------------------------------------------------
  // link clock divider
  // ------------------------------------------------------------
  scis_host_st_t st_r;
  logic [31:0] div_r;
  logic cfg_serial_clock_r;
  logic clk_run;
  logic tgl;
  logic fall;

  assign clk_run = (st_r == H_PRIME) || (st_r == H_SEND) || (st_r == H_TRAIL);
  assign tgl = clk_run && (div_r == 32'(CFG_SERIAL_CLOCK_DIV - 1));
  assign fall = tgl && cfg_serial_clock_r;

  // clock parks low between frames rather than floating
  always_ff @(posedge sys_clk) begin
    if (!rst_b || !clk_run) begin
      div_r <= 32'h0000_0000;
      cfg_serial_clock_r <= 1'b0;
    end else if (tgl) begin
      div_r <= 32'h0000_0000;
      cfg_serial_clock_r <= ~cfg_serial_clock_r;
    end else begin
      div_r <= div_r + 32'd1;
    end
  end

  // ------------------------------------------------------------
  // configuration sequence
  // ------------------------------------------------------------
  logic [1:0] stat_s_r;
  logic [1:0] done_s_r;
  logic [31:0] cnt_r;
  logic [31:0] sent_nxt;
  logic [31:0] trail_lim;
  logic [3:0] data_r;
  logic req_n_r;
  logic take_r;
  logic busy_r;
  logic ok_r;

  assign sent_nxt = cnt_r + (quad_mode ? 32'd4 : 32'd1);
  assign trail_lim = 32'(POST_DONE_FALLS) + ((init_src == SCIS_SRC_CFG_SERIAL_CLOCK && !quad_mode) ? 32'(INIT_CYCLES) : 32'd0);

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stat_s_r <= 2'h0;
      done_s_r <= 2'h0;
    end else begin
      stat_s_r <= {stat_s_r[0], lnk.status_n};
      done_s_r <= {done_s_r[0], lnk.conf_done};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      st_r <= H_BOOT;
      cnt_r <= 32'h0000_0000;
      data_r <= 4'h0;
      req_n_r <= 1'b1;
      take_r <= 1'b0;
      busy_r <= 1'b1;
      ok_r <= 1'b0;
    end else begin
      take_r <= 1'b0;
      unique case (st_r)
        H_BOOT: begin
          // priming edges obey the same status-to-clock gap as a real frame
          if (!stat_s_r[1]) begin
            cnt_r <= 32'h0000_0000;
          end else begin
            cnt_r <= cnt_r + 32'd1;
            if (cnt_r == 32'(ST2CK_CYC - 1)) begin
              cnt_r <= 32'h0000_0000;
              st_r <= H_PRIME;
            end
          end
        end
        H_PRIME: begin
          // a few edges so the far end's link logic leaves reset
          if (fall) begin
            cnt_r <= cnt_r + 32'd1;
            if (cnt_r == 32'(PRIME_EDGES - 1)) begin
              busy_r <= 1'b0;
              st_r <= H_IDLE;
            end
          end
        end
        H_IDLE: begin
          if (cfg_start) begin
            req_n_r <= 1'b0;
            cnt_r <= 32'h0000_0000;
            busy_r <= 1'b1;
            ok_r <= 1'b0;
            st_r <= H_CFG_LOW;
          end
        end
        H_CFG_LOW: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r == 32'(CFG_LOW_CYC - 1)) begin
            req_n_r <= 1'b1;
            st_r <= H_WAIT_ST;
          end
        end
        H_WAIT_ST: begin
          if (stat_s_r[1]) begin
            cnt_r <= 32'h0000_0000;
            st_r <= H_GAP;
          end
        end
        H_GAP: begin
          cnt_r <= cnt_r + 32'd1;
          if (cnt_r == 32'(ST2CK_CYC - 1)) begin
            cnt_r <= 32'h0000_0000;
            data_r <= stream_data;
            take_r <= 1'b1;
            st_r <= H_SEND;
          end
        end
        H_SEND: begin
          if (fall) begin
            cnt_r <= sent_nxt;
            if (sent_nxt >= 32'(CFG_BITS)) begin
              st_r <= H_WAIT_DONE;
            end else begin
              data_r <= stream_data;
              take_r <= 1'b1;
            end
          end
        end
        H_WAIT_DONE: begin
          if (done_s_r[1]) begin
            cnt_r <= 32'h0000_0000;
            st_r <= H_TRAIL;
          end
        end
        H_TRAIL: begin
          if (fall) begin
            cnt_r <= cnt_r + 32'd1;
            if (cnt_r == trail_lim - 32'd1) begin
              busy_r <= 1'b0;
              ok_r <= 1'b1;
              st_r <= H_IDLE;
            end
          end
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // strobes: [0] reconfiguration, [1] watchdog reset
  // ------------------------------------------------------------
  logic [1:0] stb_r;
  logic [2:0] stb_cnt_r [2];
  logic [1:0] stb_req;
  logic hold_r;
  assign stb_req = {wdog_kick_req, reconfig_req};

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stb_r <= 2'h0;
      hold_r <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        stb_cnt_r[i] <= 3'h0;
      end
    end else begin
      hold_r <= hold_status_low;
      for (int i = 0; i < 2; i++) begin
        if (stb_req[i] && !stb_r[i]) begin
          stb_r[i] <= 1'b1;
          stb_cnt_r[i] <= 3'h0;
        end else if (stb_r[i]) begin
          stb_cnt_r[i] <= stb_cnt_r[i] + 3'h1;
          if (stb_cnt_r[i] == 3'(STROBE_CYC - 1)) begin
            stb_r[i] <= 1'b0;
          end
        end
      end
    end
  end

  assign lnk.cfg_request_n = req_n_r;
  assign lnk.cfg_serial_clock = cfg_serial_clock_r;
  assign lnk.serial_config_data_in = data_r[0];
  assign lnk.flash_data_lines = data_r;
  assign lnk.host_status_pull_low = hold_r;
  assign lnk.remote_reconfig_strobe = stb_r[0];
  assign lnk.watchdog_reset_strobe = stb_r[1];
  assign stream_take = take_r;
  assign busy = busy_r;
  assign cfg_ok = ok_r;

endmodule

// *** bench/scis_link_checker.sv ***
`timescale 1ns/10ps
module scis_link_checker #(
  parameter int CFG_BITS = scis_pkg::CFG_BITS_DEF
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cfg_request_n,
  input wire logic cfg_serial_clock,
  input wire logic dev_status_pull_low,
  input wire logic status_n,
  input wire logic conf_done,
  input wire logic init_done_o,
  input wire logic init_done_oe,
  input wire logic remote_reconfig_strobe
);
  import scis_pkg::*;
  // ----
  // link edge and phase counters
  // ----
  logic clk_d_r;
  logic [15:0] low_cnt_r;
  logic [15:0] req_lo_r;
  logic [15:0] st_hi_r;
  logic [15:0] edge_r;
  logic [15:0] since_done_r;
  logic [2:0] fall_r;
  wire logic link_rise = cfg_serial_clock & ~clk_d_r;
  wire logic link_fall = ~cfg_serial_clock & clk_d_r;

  always_ff @(posedge sys_clk) clk_d_r <= cfg_serial_clock;
  // counters other than edge_r saturate so a long user mode cannot wrap them
  // cleared in reset too, so the power-up pulse is counted from release
  always_ff @(posedge sys_clk) low_cnt_r <= (!rst_b || !dev_status_pull_low) ? 16'h0000 :
    low_cnt_r + 16'(low_cnt_r != 16'hFFFF);
  always_ff @(posedge sys_clk) req_lo_r <= cfg_request_n ? 16'h0000 : req_lo_r + 16'(req_lo_r != 16'hFFFF);
  always_ff @(posedge sys_clk) st_hi_r <= !status_n ? 16'h0000 : st_hi_r + 16'(st_hi_r != 16'hFFFF);
  always_ff @(posedge sys_clk) edge_r <= dev_status_pull_low ? 16'h0000 : edge_r + 16'(link_rise);
  always_ff @(posedge sys_clk) since_done_r <= !conf_done ? 16'h0000 : since_done_r + 16'(since_done_r != 16'hFFFF);
  always_ff @(posedge sys_clk) fall_r <= !conf_done ? 3'h0 : fall_r + 3'(link_fall && fall_r != 3'h7);

  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_cfg_reset;
    dev_status_pull_low && !conf_done;
  endsequence

  // ----
  // assertions
  // ----
  a_reset_answer_fast: assert property ($fell(cfg_request_n) |-> ##[1:6] s_cfg_reset)
    else $error("status or done not low in time after request");
  a_strobe_restart: assert property ($rose(remote_reconfig_strobe) && init_done_oe && init_done_o
    |-> ##[2:10] s_cfg_reset)
    else $error("reconfiguration strobe did not restart");
  a_status_low_min: assert property ($fell(dev_status_pull_low) |-> low_cnt_r >= STATUS_LOW_CYC - 1)
    else $error("status low pulse too short");
  a_status_low_max: assert property (low_cnt_r <= 16'h3AD4)
    else $error("status held low too long");
  a_request_width: assert property ($rose(cfg_request_n) |-> req_lo_r >= CFG_LOW_CYC)
    else $error("request low pulse too short");
  a_first_edge_gap: assert property (link_rise |-> st_hi_r >= ST2CK_CYC)
    else $error("link clock rose too soon after status");
  a_done_after_bits: assert property ($rose(conf_done) |-> edge_r == CFG_BITS || edge_r == CFG_BITS / 4)
    else $error("done rose after wrong number of clock edges");
  a_init_pin_low: assert property ($rose(init_done_oe) |-> !init_done_o)
    else $error("init done pin not low when enabled");
  a_user_mode_entry: assert property ($rose(init_done_o)
    |-> conf_done && fall_r >= POST_DONE_FALLS && since_done_r <= 16'h1112)
    else $error("user mode entered without falls or too late");
endmodule

// *** bench/test_serial_config_init_sequencer.sv ***
`timescale 1ns/10ps
module test_serial_config_init_sequencer;
  import scis_pkg::*;
  localparam int BITS = CFG_BITS_DEF;
  localparam int INIT = 16;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic user_startup_clock = 1'b0;
  scis_init_src_t init_src = SCIS_SRC_CFG_SERIAL_CLOCK;
  logic quad_mode = 1'b0;
  logic wdog_en = 1'b0;
  logic cfg_start = 1'b0;
  logic reconfig_req = 1'b0;
  logic wdog_kick_req = 1'b0;
  logic [3:0] stream_data = 4'h5;
  logic user_mode, user_io_in, wdog_fired, stream_take, busy, cfg_ok;
  int takes = 0;
  int n_fail = 0;
  int checks = 0;

  always #50 sys_clk = ~sys_clk;
  // user clock kept below half the system rate for the device's sampler
  always #240 user_startup_clock = ~user_startup_clock;

  scis_link_if u_scis_link_if ();
  scis_device #(.CFG_BITS(BITS), .INIT_CYCLES(INIT), .WDOG_CYCLES(200)) u_scis_device (
    .sys_clk(sys_clk), .rst_b(rst_b), .lnk(u_scis_link_if.device), .user_startup_clock(user_startup_clock),
    .init_src(init_src), .quad_mode(quad_mode), .dual_purpose_en(1'b1), .wdog_en(wdog_en),
    .user_mode(user_mode), .user_io_in(user_io_in), .wdog_fired(wdog_fired));
  scis_host #(.CFG_BITS(BITS), .INIT_CYCLES(INIT), .CFG_SERIAL_CLOCK_DIV(CFG_SERIAL_CLOCK_DIV_DEF)) u_scis_host (
    .sys_clk(sys_clk), .rst_b(rst_b), .lnk(u_scis_link_if.host), .cfg_start(cfg_start), .quad_mode(quad_mode),
    .init_src(init_src), .hold_status_low(1'b0), .stream_data(stream_data), .reconfig_req(reconfig_req),
    .wdog_kick_req(wdog_kick_req), .stream_take(stream_take), .busy(busy), .cfg_ok(cfg_ok));
  scis_link_checker #(.CFG_BITS(BITS)) u_scis_link_checker (
    .sys_clk(sys_clk), .rst_b(rst_b), .cfg_request_n(u_scis_link_if.cfg_request_n),
    .cfg_serial_clock(u_scis_link_if.cfg_serial_clock), .dev_status_pull_low(u_scis_link_if.dev_status_pull_low),
    .status_n(u_scis_link_if.status_n), .conf_done(u_scis_link_if.conf_done),
    .init_done_o(u_scis_link_if.init_done_o), .init_done_oe(u_scis_link_if.init_done_oe),
    .remote_reconfig_strobe(u_scis_link_if.remote_reconfig_strobe));

  always @(posedge sys_clk) begin
    if (stream_take) begin
      takes <= takes + 1;
      // even step keeps bit 0 high: init-done pin enabled, data pin ends high
      stream_data <= stream_data + 4'h6;
    end
  end

  task automatic chk_bit(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_cnt(input string what, input int exp, input int got);
    checks++;
    if (got != exp) begin
      n_fail++;
      $display("unexpected %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  task automatic wait_on(input string what, ref logic sig, input logic val, input int lim, output int n);
    n = 0;
    while (sig !== val && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    chk_bit(what, val, sig);
  endtask

  task automatic run_cfg(input logic q, input scis_init_src_t s, input int lo, input int hi);
    int n;
    wait_on("host idle", busy, 1'b0, 8000, n);
    quad_mode <= q;
    init_src <= s;
    @(posedge sys_clk);
    takes = 0;
    cfg_start <= 1'b1;
    @(posedge sys_clk);
    cfg_start <= 1'b0;
    // from user mode done must drop first, else the rise below is stale
    wait_on("done drop", u_scis_link_if.conf_done, 1'b0, 20, n);
    wait_on("done rise", u_scis_link_if.conf_done, 1'b1, 30000, n);
    wait_on("user mode", user_mode, 1'b1, 6000, n);
    chk_bit("init span", 1'b1, n >= lo && n <= hi);
    wait_on("host ok", cfg_ok, 1'b1, 200, n);
    chk_bit("user done", 1'b1, u_scis_link_if.conf_done);
    chk_bit("user status", 1'b1, u_scis_link_if.status_n);
    chk_bit("init pin", 1'b1, u_scis_link_if.init_done);
    chk_cnt("units", q ? BITS / 4 : BITS, takes);
    @(posedge sys_clk);
    chk_bit("user io", 1'b1, user_io_in);
  endtask

  task automatic results();
    if (n_fail == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #4_000_000;
    n_fail++;
    results();
  end

  initial begin
    int n;
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    repeat (10) @(posedge sys_clk);
    chk_bit("status after reset", 1'b0, u_scis_link_if.status_n);
    chk_bit("done after reset", 1'b0, u_scis_link_if.conf_done);
    run_cfg(1'b0, SCIS_SRC_CFG_SERIAL_CLOCK, INIT * 2 * CFG_SERIAL_CLOCK_DIV_DEF, 4370);
    run_cfg(1'b1, SCIS_SRC_OSC, OSC_INIT_CYC, 4370);
    reconfig_req <= 1'b1;
    @(posedge sys_clk);
    reconfig_req <= 1'b0;
    wait_on("done restart", u_scis_link_if.conf_done, 1'b0, 20, n);
    wait_on("status restart", u_scis_link_if.status_n, 1'b0, 4, n);
    run_cfg(1'b0, SCIS_SRC_USR, INIT * 48 / 10, 4370);
    wdog_en <= 1'b1;
    // kicks at half the timeout keep the timer from expiring
    repeat (6) begin
      repeat (100) @(posedge sys_clk);
      wdog_kick_req <= 1'b1;
      @(posedge sys_clk);
      wdog_kick_req <= 1'b0;
    end
    chk_bit("kicked timer", 1'b0, wdog_fired);
    wait_on("timer expiry", wdog_fired, 1'b1, 500, n);
    chk_bit("mode after expiry", 1'b0, user_mode);
    results();
  end
endmodule
